/* File: rtl/sic_irq_ctrl.sv */
/*
  Interrupt-enable registers of the clock and supply controller, an APB
  slave with byte strobes, sticky source flags and one interrupt line.
  Assumes an APB4 master on ref_clk and source events synchronous to it.
*/
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "sic_defs.svh"

// Notes on behaviour
// R01: Accept 8, 16 and 32 bit accesses
// R02: Each byte lane addressable for read/write
// R03: Unsynchronized registers answer with no wait
// R04: Guarded writes leave the enables unchanged
// R05: Enable clear at 0x00, resets to zero
// R06: Zero written to clear leaves enable alone
// R07: One written to clear disables the source
// R08: Enable reads back; enabled flag raises request
// R09: Bits 0-3 oscillator ready enables
// R10: Bits 4-8 frequency loop enables
// R11: Bits 9-11 brownout detector enables
// R12: Set register at 0x04 sets enables
// R13: Bits 12-31 read zero, ignore writes
// R14: Request is OR of flag AND enable
module sic_irq_ctrl #(
  parameter int NUM_SRC = `SIC_NUM_SRC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire sic_pkg::sic_addr_type paddr,
  input wire sic_pkg::sic_word_type pwdata,
  input wire sic_pkg::sic_strb_type pstrb,
  output sic_pkg::sic_word_type prdata,
  output logic pready,
  output logic pslverr,
  input wire logic peripheral_write_guard,
  input wire sic_pkg::sic_src_type src_event,
  output sic_pkg::sic_src_type irq_enable,
  output logic irq
);
  import sic_pkg::*;

  sic_flag_if #(.N(NUM_SRC)) fl ();

  logic pready_q;
  logic pslverr_q;
  sic_word_type prdata_q;
  sic_src_type en_q;
  sic_src_type en_d;
  sic_src_type en_out_q;
  logic irq_q;
  logic setup;
  logic access;
  logic hit_clr;
  logic hit_set;
  logic hit_flags;
  logic hit_any;
  sic_word_type lane_mask;
  sic_word_type wbits;
  sic_src_type wmask;
  logic wr_clr;
  logic wr_set;
  logic wr_flags;
  logic guarded;
  logic irq_next;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign hit_clr = (paddr == `SIC_OFS_IE_CLEAR); // R05
  assign hit_set = (paddr == `SIC_OFS_IE_SET); // R12
  assign hit_flags = (paddr == `SIC_OFS_IRQ_FLAGS);
  assign hit_any = hit_clr || hit_set || hit_flags;
  // Protection covers the enable pair only; flags stay clearable
  assign guarded = peripheral_write_guard && (hit_clr || hit_set);

  // Unstrobed lanes count as zeros, which is a no-op for these registers
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      lane_mask[b*8 +: 8] = {8{pstrb[b]}}; // R01 R02
    end
  end

  assign wbits = pwdata & lane_mask; // R02
  assign wmask = wbits[NUM_SRC-1:0]; // R13
  assign wr_clr = access && pwrite && hit_clr && !peripheral_write_guard; // R04
  assign wr_set = access && pwrite && hit_set && !peripheral_write_guard; // R04
  assign wr_flags = access && pwrite && hit_flags;

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  // No register here needs a domain crossing, so every access ends after
  // exactly one access cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup; // R03
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !hit_any || (pwrite && guarded); // R04
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h00000000;
    end else if (setup && !pwrite) begin
      // Whole word returned; the master picks the lanes it asked for
      prdata_q <= 32'h00000000; // R13
      if (hit_clr || hit_set) begin
        prdata_q[NUM_SRC-1:0] <= en_q; // R08
      end else if (hit_flags) begin
        prdata_q[NUM_SRC-1:0] <= fl.flags;
      end
    end else if (!psel) begin
      prdata_q <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Enable state
  // ----------------------------------------------------------------------
  // Source order: oscillators at 0-3, loop at 4-8, brownout at 9-11
  always_comb begin
    en_d = en_q;
    if (wr_clr) begin
      en_d = en_q & ~wmask; // R06 R07 R09 R10 R11
    end
    if (wr_set) begin
      en_d = en_q | wmask; // R12
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= NUM_SRC'(`SIC_RST_IE); // R05
    end else begin
      en_q <= en_d;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_out_q <= NUM_SRC'(`SIC_RST_IE);
    end else begin
      en_out_q <= en_d;
    end
  end

  // ----------------------------------------------------------------------
  // Flags and request
  // ----------------------------------------------------------------------
  assign fl.evt = src_event;
  assign fl.clr = wr_flags ? wmask : '0;

  sic_flag_bank #(.N(NUM_SRC)) u_flags (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .fl(fl)
  );

  // Registered, so the line trails the flag or enable by one cycle
  assign irq_next = |(fl.flags & en_q); // R08 R14

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_next; // R08 R14
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_enable = en_out_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_NO_WAIT: assert property (@(posedge ref_clk) disable iff (!arst_n) // R03
    setup |=> (pready_q && psel && penable) or (!psel))
    else $error("Access phase not answered at once");

  AST_GUARD_HOLDS: assert property (@(posedge ref_clk) disable iff (!arst_n) // R04
    (access && pwrite && (hit_clr || hit_set) && peripheral_write_guard) |=> (en_q == $past(en_q)))
    else $error("Guarded write changed enables");

  AST_CLEAR_ONES: assert property (@(posedge ref_clk) disable iff (!arst_n) // R07
    wr_clr |=> ((en_q & $past(wmask)) == '0))
    else $error("Clear write left an enable set");

  AST_CLEAR_ZEROS: assert property (@(posedge ref_clk) disable iff (!arst_n) // R06
    wr_clr |=> ((en_q & ~$past(wmask)) == ($past(en_q) & ~$past(wmask))))
    else $error("Zero in clear write changed an enable");

  AST_SET_ONES: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
    wr_set |=> ((en_q & $past(wmask)) == $past(wmask) && (en_q & ~$past(wmask)) == ($past(en_q) & ~$past(wmask))))
    else $error("Set write did not set exactly its ones");

  AST_LANE_ISOLATION: assert property (@(posedge ref_clk) disable iff (!arst_n) // R02
    ((wr_clr || wr_set) && pstrb == 4'h1) |=> (en_q[NUM_SRC-1:8] == $past(en_q[NUM_SRC-1:8])))
    else $error("Byte write touched an unstrobed lane");

  AST_READBACK: assert property (@(posedge ref_clk) disable iff (!arst_n) // R08
    (access && !pwrite && (hit_clr || hit_set)) |-> (prdata_q[NUM_SRC-1:0] == en_q))
    else $error("Enable read returned wrong value");

  AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n) // R13
    (access && !pwrite) |-> (prdata_q[31:NUM_SRC] == '0))
    else $error("Reserved bits read nonzero");

  AST_IRQ_COMBINE: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
    ##1 (irq_q == $past(irq_next)))
    else $error("Interrupt line disagrees with flags and enables");

  AST_UNMAPPED_ERR: assert property (@(posedge ref_clk) disable iff (!arst_n) // R01
    (setup && !hit_any) |=> (pslverr_q && pready_q))
    else $error("Unmapped access not flagged");

  // ----------------------------------------------------------------------
  // Bus timing checks
  // ----------------------------------------------------------------------
  AST_READY_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!arst_n) // R03
    pready_q |=> !pready_q)
    else $error("Ready held past one access cycle");

  AST_READY_AFTER_SETUP: assert property (@(posedge ref_clk) disable iff (!arst_n) // R03
    pready_q |-> $past(setup))
    else $error("Ready without a setup cycle");

  AST_ERR_WITH_READY: assert property (@(posedge ref_clk) disable iff (!arst_n) // R01
    pslverr_q |-> pready_q)
    else $error("Error response without ready");

  AST_IDLE_DATA_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n) // R08
    !psel |=> (prdata_q == '0))
    else $error("Read data not cleared while idle");

  AST_GUARD_ERR: assert property (@(posedge ref_clk) disable iff (!arst_n) // R04
    (setup && pwrite && guarded) |=> pslverr_q)
    else $error("Guarded write not flagged");

  AST_OPEN_WRITE_NO_ERR: assert property (@(posedge ref_clk) disable iff (!arst_n) // R04
    (setup && pwrite && hit_any && !guarded) |=> !pslverr_q)
    else $error("Unguarded mapped write flagged");

  AST_FLAG_WRITE_FREE: assert property (@(posedge ref_clk) disable iff (!arst_n) // R04
    (access && pwrite && hit_flags) |-> !pslverr_q)
    else $error("Flag write refused");

  // ----------------------------------------------------------------------
  // Enable and request checks
  // ----------------------------------------------------------------------
  AST_HOLD_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n) // R06
    !(wr_clr || wr_set) |=> (en_q == $past(en_q)))
    else $error("Enables changed without a write");

  AST_READ_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (!arst_n) // R08
    (access && !pwrite) |=> (en_q == $past(en_q)))
    else $error("Read changed enables");

  AST_OTHER_WRITE_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (!arst_n) // R05
    (access && pwrite && !(hit_clr || hit_set)) |=> (en_q == $past(en_q)))
    else $error("Write elsewhere changed enables");

  AST_UPPER_LANES_IGNORED: assert property (@(posedge ref_clk) disable iff (!arst_n) // R13
    ((wr_clr || wr_set) && pstrb[1:0] == 2'b00) |=> (en_q == $past(en_q)))
    else $error("Upper lane write changed enables");

  AST_LANE1_ISOLATION: assert property (@(posedge ref_clk) disable iff (!arst_n) // R02
    ((wr_clr || wr_set) && pstrb == 4'h2) |=> (en_q[7:0] == $past(en_q[7:0])))
    else $error("Lane one write touched lane zero");

  AST_PORT_COPY: assert property (@(posedge ref_clk) disable iff (!arst_n) // R08
    en_out_q == en_q)
    else $error("Enable port differs from enables");

  AST_EVENT_SETS_FLAG: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
    (src_event != '0) |=> ((fl.flags & $past(src_event)) == $past(src_event)))
    else $error("Source event did not set its flag");

  AST_MASKED_QUIET: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
    (en_q == '0) |=> !irq_q)
    else $error("Request raised with all sources disabled");

endmodule // sic_irq_ctrl

/* File: rtl/sic_defs.svh */
/*
  Offsets, field positions, reset values and counts of the clock controller
  interrupt-enable block.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SIC_DEFS_SVH
`define SIC_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SIC_ADDR_W 12
`define SIC_OFS_IE_CLEAR 12'h000
`define SIC_OFS_IE_SET 12'h004
`define SIC_OFS_IRQ_FLAGS 12'h008
`define SIC_RST_IE 32'h00000000
`define SIC_RST_FLAGS 12'h000

// ----------------------------------------------------------------------
// Source bit positions
// ----------------------------------------------------------------------
`define SIC_NUM_SRC 12
`define SIC_BIT_CRYSTAL_OSC_READY 0
`define SIC_BIT_CRYSTAL_32KHZ_READY 1
`define SIC_BIT_INTERNAL_32KHZ_OSC_READY 2
`define SIC_BIT_INTERNAL_8MHZ_OSC_READY 3
`define SIC_BIT_FREQ_LOOP_READY 4
`define SIC_BIT_FREQ_LOOP_OUT_OF_BOUNDS 5
`define SIC_BIT_FREQ_LOOP_FINE_LOCK 6
`define SIC_BIT_FREQ_LOOP_COARSE_LOCK 7
`define SIC_BIT_FREQ_LOOP_REF_STOPPED 8
`define SIC_BIT_BROWNOUT_READY 9
`define SIC_BIT_BROWNOUT_DETECT 10
`define SIC_BIT_BROWNOUT_SYNC_READY 11

`endif

/* File: rtl/sic_pkg.sv */
/*
  Types shared by the interrupt-enable block.
  Assumes the constants header is on the include path.
*/
`include "sic_defs.svh"

package sic_pkg;
  typedef logic [`SIC_NUM_SRC-1:0] sic_src_type;
  typedef logic [31:0] sic_word_type;
  typedef logic [3:0] sic_strb_type;
  typedef logic [`SIC_ADDR_W-1:0] sic_addr_type;
endpackage

/* File: rtl/sic_flag_if.sv */
/*
  Carrier between the bus front end and the sticky flag bank.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps

interface sic_flag_if #(
  parameter int N = 12
);
  logic [N-1:0] evt;
  logic [N-1:0] clr;
  logic [N-1:0] flags;
  modport bank (input evt, input clr, output flags);
  modport ctrl (output evt, output clr, input flags);
endinterface

/* File: rtl/sic_flag_bank.sv */
/*
  Sticky event flags, one per interrupt source, cleared by a bit mask that may hold several ones.
  Assumes evt and clr are synchronous single-cycle or level inputs.
*/
`timescale 1ns/100ps

module sic_flag_bank #(
  parameter int N = 12
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  sic_flag_if.bank fl
);
  import sic_pkg::*;

  logic [N-1:0] flags_q;
  logic [N-1:0] flags_d;
  logic [N-1:0] collide;

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  // A new event beats a clear in the same cycle so no edge is lost
  always_comb begin
    flags_d = (flags_q & ~fl.clr) | fl.evt;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;
  assign collide = fl.evt & fl.clr;

  AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (collide != '0) |=> ((flags_q & $past(collide)) == $past(collide)))
    else $error("Event lost against a simultaneous clear");

endmodule // sic_flag_bank

/* File: test/sic_apb_master.sv */
/*
  Processor-side APB4 master model for the interrupt-enable block.
  Assumes a single ref_clk domain; the bench calls xfer one transfer at a time.
*/
`timescale 1ns/100ps

module sic_apb_master (
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output sic_pkg::sic_addr_type paddr,
  output sic_pkg::sic_word_type pwdata,
  output sic_pkg::sic_strb_type pstrb,
  input wire sic_pkg::sic_word_type prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import sic_pkg::*;
  int waits;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    waits = 0;
  end
  // ----------------------------------------------------------------------
  // One transfer: setup, access until pready, then release
  // ----------------------------------------------------------------------
  task automatic xfer(input logic wr, input sic_addr_type a, input sic_word_type d, input sic_strb_type s,
                      output sic_word_type rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    waits = 0;
    // Ready and data are read at the rising edge, before the slave updates them
    forever begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
      waits++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data lines show a changed pattern, not the stale word
    pwdata <= ~d;
    pstrb <= ~s;
  endtask
endmodule // sic_apb_master

/* File: test/tb_sic_irq_ctrl.sv */
/*
  Self-checking bench for the interrupt-enable block: enable set and clear,
  byte lanes, write guard, unmapped access and the interrupt line.
  Assumes the APB master model and the design files are compiled first.
*/
`timescale 1ns/100ps
`include "sic_defs.svh"

module tb_sic_irq_ctrl;
  import sic_pkg::*;
  logic ref_clk, arst_n, guard, psel, penable, pwrite, pready, pslverr, irq, err;
  sic_addr_type paddr;
  sic_word_type pwdata, prdata, rd;
  sic_strb_type pstrb;
  sic_src_type src_event, irq_enable;
  int failures = 0;
  int comparisons = 0;
  localparam sic_addr_type CLR = `SIC_OFS_IE_CLEAR;
  localparam sic_addr_type SET = `SIC_OFS_IE_SET;
  localparam sic_addr_type FLG = `SIC_OFS_IRQ_FLAGS;
  localparam sic_word_type BD = 32'h1 << `SIC_BIT_BROWNOUT_DETECT;

  sic_irq_ctrl dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .peripheral_write_guard(guard), .src_event(src_event), .irq_enable(irq_enable), .irq(irq));
  sic_apb_master mst (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input sic_word_type seen, input sic_word_type exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input sic_addr_type a, input sic_word_type d, input sic_strb_type s);
    mst.xfer(1'b1, a, d, s, rd, err);
  endtask
  task automatic rdw(input sic_addr_type a);
    mst.xfer(1'b0, a, 32'h0, 4'h0, rd, err);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rdw(CLR);
    check("clear reset", rd, 32'h0);
    check("wait states", 32'(mst.waits), 32'h0);
    rdw(SET);
    check("set reset", rd, 32'h0);
    check("irq reset", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_each_source();
    for (int i = 0; i < 12; i++) begin
      wr(SET, 32'h1 << i, 4'hf);
      rdw(CLR);
      check("set walk", rd, (32'h1 << (i + 1)) - 32'h1);
      check("enable port", 32'(irq_enable), (32'h1 << (i + 1)) - 32'h1);
    end
    wr(SET, 32'hfffff000, 4'hf);
    rdw(SET);
    check("upper bits", rd, 32'h00000fff);
    wr(CLR, 32'h0, 4'hf);
    rdw(CLR);
    check("clear zero", rd, 32'h00000fff);
    wr(CLR, 32'h00000401, 4'hf);
    rdw(CLR);
    check("clear ones", rd, 32'h00000bfe);
    wr(CLR, 32'hffffffff, 4'hf);
  endtask
  task automatic t_lanes();
    wr(SET, 32'hffffffff, 4'b0010);
    check("lane err", {31'h0, err}, 32'h0);
    rdw(CLR);
    check("byte lane 1", rd, 32'h00000f00);
    wr(SET, 32'hffffffff, 4'b0001);
    wr(CLR, 32'hffffffff, 4'b1100);
    rdw(CLR);
    check("upper half", rd, 32'h00000fff);
    wr(CLR, 32'h0000ffff, 4'b0011);
    rdw(CLR);
    check("lower half", rd, 32'h0);
  endtask
  task automatic t_guard();
    guard <= 1'b1;
    wr(SET, 32'h00000fff, 4'hf);
    check("guard err", {31'h0, err}, 32'h1);
    rdw(CLR);
    check("guarded set", rd, 32'h0);
    guard <= 1'b0;
    wr(SET, 32'h00000fff, 4'hf);
    guard <= 1'b1;
    wr(CLR, 32'h00000fff, 4'hf);
    rdw(CLR);
    check("guarded clear", rd, 32'h00000fff);
    guard <= 1'b0;
    wr(CLR, 32'h00000fff, 4'hf);
  endtask
  task automatic t_irq();
    wr(SET, BD, 4'hf);
    src_event <= BD[11:0] | 12'h001;
    @(posedge ref_clk);
    src_event <= 12'h000;
    settle(1);
    check("irq enabled", {31'h0, irq}, 32'h1);
    rdw(FLG);
    check("flags", rd, BD | 32'h1);
    wr(CLR, BD, 4'hf);
    settle(1);
    // The crystal and brownout detect flags stay pending, and both are masked
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(SET, 32'h1, 4'hf);
    settle(1);
    check("irq late enable", {31'h0, irq}, 32'h1);
    wr(FLG, BD | 32'h1, 4'hf);
    settle(1);
    check("irq flag cleared", {31'h0, irq}, 32'h0);
    // An event at the very edge of a flag clear must survive it
    fork
      wr(FLG, 32'h2, 4'hf);
      begin
        repeat (2) @(posedge ref_clk);
        src_event <= 12'h002;
        @(posedge ref_clk);
        src_event <= 12'h000;
      end
    join
    rdw(FLG);
    check("set beats clear", rd, 32'h2);
    wr(FLG, 32'h2, 4'hf);
    wr(CLR, 32'h1, 4'hf);
  endtask
  task automatic t_unmapped();
    wr(SET, 32'h00000030, 4'hf);
    rdw(12'h00c);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    wr(12'h00c, 32'hffffffff, 4'hf);
    rdw(CLR);
    check("unmapped write", rd, 32'h00000030);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Far beyond the few hundred cycles the scenarios need
  initial begin
    #2000000;
    failures++;
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0;
    guard = 1'b0;
    src_event = 12'h000;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_each_source();
    t_lanes();
    t_guard();
    t_irq();
    t_unmapped();
    tally_and_finish();
  end
endmodule // tb_sic_irq_ctrl
